// ==== mtis_issue_scheduler.v ====
// Issue scheduler for the logical cores of one tile.
// Assumes synchronous inputs on ref_clk; event sources hold their event pulse for one cycle.
`include "mtis_regs.vh"
module mtis_issue_scheduler #(
	parameter NUM_CORES = `MTIS_NUM_CORES,
	parameter STAGES    = `MTIS_PIPE_STAGES
)(
	ref_clk,
	resetn,
	coreEnable,
	pauseReq,
	resumeEvent,
	ioStall,
	issueValid,
	issueCore,
	issueOneHot,
	pausedMask,
	activeCount
);
	localparam W = `MTIS_CORE_ID_W;
	input  wire                 ref_clk;
	input  wire                 resetn;
	input  wire [NUM_CORES-1:0] coreEnable;
	input  wire [NUM_CORES-1:0] pauseReq;
	input  wire [NUM_CORES-1:0] resumeEvent;
	input  wire [NUM_CORES-1:0] ioStall;
	output reg                  issueValid;
	output reg  [W-1:0]         issueCore;
	output reg  [NUM_CORES-1:0] issueOneHot;
	output reg  [NUM_CORES-1:0] pausedMask;
	output reg  [W:0]           activeCount;

	localparam HIST = STAGES - 1;

	// Next values of the registered outputs.
	reg                 issueValid_next;
	reg [W-1:0]         issueCore_next;
	reg [NUM_CORES-1:0] issueOneHot_next;
	reg [NUM_CORES-1:0] pausedMask_next;
	reg [W:0]           activeCount_next;

	// Round-robin pointer: the core that issued last.
	reg [W-1:0]         lastPick_reg;
	reg [W-1:0]         lastPick_next;

	// Issue history of the last STAGES-1 slots, one core id per slot.
	reg [W-1:0]         histCore_reg [0:HIST-1];
	reg                 histValid_reg [0:HIST-1];

	// Combinational selection terms.
	reg [NUM_CORES-1:0] pauseSet;
	reg [NUM_CORES-1:0] pauseClear;
	reg [NUM_CORES-1:0] recentMask;
	reg [NUM_CORES-1:0] readyMask;
	reg [NUM_CORES-1:0] eligibleMask;
	reg [W-1:0]         candidate;
	reg [W-1:0]         pick;
	reg                 found;
	integer             i;
	integer             j;
	integer             k;

	// One-hot mask of a single core id.
	function [NUM_CORES-1:0] core_bit;
		input [W-1:0] id;
		begin
			core_bit = {{(NUM_CORES-1){1'h0}}, 1'h1} << id;
		end
	endfunction

	// Number of set bits in a core mask.
	function [W:0] count_ones;
		input [NUM_CORES-1:0] mask;
		integer b;
		begin
			count_ones = {(W+1){1'h0}};
			for (b = 0; b < NUM_CORES; b = b + 1)
			begin
				count_ones = count_ones + {{W{1'h0}}, mask[b]};
			end
		end
	endfunction

	// A resume or a disable in the same cycle beats a new pause.
	always @*
	begin
		pauseSet        = pauseReq & coreEnable;
		pauseClear      = resumeEvent | ~coreEnable;
		pausedMask_next = (pausedMask | pauseSet) & ~pauseClear;
	end

	// Cores still in the pipeline, taken from the issue history.
	always @*
	begin
		recentMask = {NUM_CORES{1'h0}};
		for (i = 0; i < HIST; i = i + 1)
		begin
			if (histValid_reg[i])
			begin
				recentMask = recentMask | core_bit(histCore_reg[i]);
			end
		end
	end

	always @*
	begin
		// Paused cores are out of rotation; stalled cores yield their slot.
		readyMask    = coreEnable & ~pausedMask & ~ioStall;
		// A core still in the pipeline waits, so it gets at most one slot in STAGES.
		eligibleMask = readyMask & ~recentMask;
	end

	// Round-robin search starting just after the core that issued last.
	always @*
	begin
		found     = 1'h0;
		pick      = lastPick_reg;
		candidate = lastPick_reg;
		for (k = 1; k <= NUM_CORES; k = k + 1)
		begin
			candidate = lastPick_reg + k[W-1:0];
			if (!found && eligibleMask[candidate])
			begin
				found = 1'h1;
				pick  = candidate;
			end
		end
	end

	always @*
	begin
		issueValid_next  = found;
		issueCore_next   = pick;
		activeCount_next = count_ones(coreEnable);
		if (found)
		begin
			issueOneHot_next = core_bit(pick);
			lastPick_next    = pick;
		end
		else
		begin
			issueOneHot_next = {NUM_CORES{1'h0}};
			lastPick_next    = lastPick_reg;
		end
	end

	always @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			pausedMask <= `MTIS_PAUSED_RESET;
		end
		else
		begin
			pausedMask <= pausedMask_next;
		end
	end

	// Issue outputs answer the inputs of the edge that launches them.
	always @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			issueValid  <= `MTIS_VALID_RESET;
			issueCore   <= `MTIS_CORE_RESET;
			issueOneHot <= `MTIS_ONEHOT_RESET;
		end
		else
		begin
			issueValid  <= issueValid_next;
			issueCore   <= issueCore_next;
			issueOneHot <= issueOneHot_next;
		end
	end

	always @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			activeCount <= `MTIS_COUNT_RESET;
		end
		else
		begin
			activeCount <= activeCount_next;
		end
	end

	// The pointer resets to the top core so that core 0 is searched first.
	always @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			lastPick_reg <= `MTIS_LAST_RESET;
		end
		else
		begin
			lastPick_reg <= lastPick_next;
		end
	end

	// Shift register of issued ids; a slot without issue is marked invalid.
	always @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			for (j = 0; j < HIST; j = j + 1)
			begin
				histCore_reg[j]  <= `MTIS_HISTORY_RESET;
				histValid_reg[j] <= `MTIS_HIST_VALID_RESET;
			end
		end
		else
		begin
			histCore_reg[0]  <= pick;
			histValid_reg[0] <= found;
			for (j = 1; j < HIST; j = j + 1)
			begin
				histCore_reg[j]  <= histCore_reg[j-1];
				histValid_reg[j] <= histValid_reg[j-1];
			end
		end
	end
endmodule // mtis_issue_scheduler

// ==== mtis_regs.vh ====
// Constants of the multithread issue scheduler.
// Assumes inclusion by bare name from the scheduler module.
`ifndef MTIS_REGS_VH
`define MTIS_REGS_VH
`define MTIS_NUM_CORES      8
`define MTIS_PIPE_STAGES    4
`define MTIS_CORE_ID_W      3
`define MTIS_ACTIVE_RESET   8'h00
`define MTIS_PAUSED_RESET   8'h00
`define MTIS_HISTORY_RESET  3'h0
`define MTIS_HIST_VALID_RESET 1'h0
`define MTIS_VALID_RESET    1'h0
`define MTIS_CORE_RESET     3'h0
`define MTIS_ONEHOT_RESET   8'h00
`define MTIS_COUNT_RESET    4'h0
`define MTIS_LAST_RESET     3'h7
`endif

// ==== mtis_checker.sv ====
// Port checker of the issue scheduler.
module mtis_checker(input wire ref_clk, resetn, issueValid, input wire [2:0] issueCore, input wire [3:0] activeCount,
	input wire [7:0] coreEnable, pauseReq, resumeEvent, ioStall, issueOneHot, pausedMask);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic [7:0] h1, h2, h3;
	wire [7:0] pv = pauseReq & coreEnable & ~resumeEvent;
	always @(posedge ref_clk) {h3, h2, h1} <= {h2, h1, issueOneHot};
	hot_bit_a: assert property (issueValid |-> issueOneHot == 8'h01 << issueCore) else $error("hot");
	idle_zero_a: assert property (!issueValid |-> !issueOneHot) else $error("idle");
	slot_gap_a: assert property (!(issueOneHot & (h1 | h2 | h3))) else $error("gap");
	ready_only_a: assert property (issueValid |-> $past(coreEnable) & ~$past(ioStall) & issueOneHot) else $error("rdy");
	pause_skip_a: assert property (!(issueOneHot & $past(pausedMask) & ~$past(resumeEvent))) else $error("skip");
	pause_take_a: assert property (pv |=> (pausedMask & $past(pv)) == $past(pv)) else $error("pause");
	resume_clr_a: assert property (resumeEvent |=> !(pausedMask & $past(resumeEvent))) else $error("res");
	active_cnt_a: assert property (activeCount == $countones($past(coreEnable))) else $error("cnt");
	cover property (issueCore == 3'h7);
	cover property (resumeEvent);
	cover property (ioStall && issueValid);
endmodule // mtis_checker
bind mtis_issue_scheduler mtis_checker chk(.*);

// ==== mtis_event_model.sv ====
// Event source: pulses resumeEvent for the paused cores DELAY+1 cycles after pausedMask goes nonzero.
module mtis_event_model #(parameter DELAY = 3) (input wire ref_clk, input wire [7:0] pausedMask,
	output logic [7:0] resumeEvent = 8'h00);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] t = 4'h0;
	always @(posedge ref_clk)
	begin
		t <= pausedMask ? t + 4'h1 : 4'h0;
		resumeEvent <= t == DELAY ? pausedMask : 8'h00;
	end
endmodule // mtis_event_model

// ==== mtis_issue_scheduler_tb.sv ====
// Bench of the scheduler; checker bound alongside.
module mtis_issue_scheduler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, resetn = 0, issueValid;
	logic [7:0] coreEnable = 0, pauseReq = 0, ioStall = 0, resumeEvent, issueOneHot, pausedMask;
	logic [2:0] issueCore;
	logic [3:0] activeCount;
	int n_mismatch = 0, tests_run = 0;
	mtis_issue_scheduler dut(.*);
	mtis_event_model em(.*);
	initial forever #20 ref_clk = ~ref_clk;
	initial #20000 begin n_mismatch++; conclude; end
	task ex(input logic [7:0] o);
		@(negedge ref_clk) tests_run++;
		if (issueOneHot !== o || issueValid !== (o != 0) || (o != 0 && 8'h01 << issueCore !== o))
		begin
			n_mismatch++;
			$display("unexpected %0t issue %h", $time, issueOneHot);
		end
	endtask
	task ep(input logic [7:0] o);
		tests_run++;
		if (pausedMask !== o)
		begin
			n_mismatch++;
			$display("unexpected %0t paused %h", $time, pausedMask);
		end
	endtask
	task ec(input logic [3:0] o);
		tests_run++;
		if (activeCount !== o)
		begin
			n_mismatch++;
			$display("unexpected %0t count %h", $time, activeCount);
		end
	endtask
	task go(input logic [7:0] e, s = 0, p = 0);
		@(posedge ref_clk) {resetn, coreEnable, pauseReq, ioStall} <= 0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1;
		@(posedge ref_clk) {coreEnable, ioStall, pauseReq} <= {e, s, p};
		ex(0);
	endtask
	task t_quarter;
		go(8'h0f);
		for (int i = 0; i < 5; i++) ex(8'h01 << i % 4);
		ec(4'h4);
		$display("quarter done");
	endtask
	task t_single;
		go(8'h20);
		for (int i = 0; i < 5; i++) ex(i % 4 ? 8'h00 : 8'h20);
		ec(4'h1);
		$display("single done");
	endtask
	task t_eight;
		go(8'hff);
		for (int i = 0; i < 9; i++) ex(8'h01 << i % 8);
		ec(4'h8);
		$display("eight done");
	endtask
	task t_stall;
		logic [7:0] q[6] = '{1, 4, 8, 'h10, 'h20, 1};
		go(8'h3f, 8'h02);
		foreach (q[i]) ex(q[i]);
		ec(4'h6);
		$display("stall done");
	endtask
	task t_pause;
		logic [7:0] q[8] = '{1, 4, 8, 0, 1, 4, 8, 2};
		go(8'h0f, 0, 8'h02);
		@(posedge ref_clk) pauseReq <= 0;
		foreach (q[i])
		begin
			ex(q[i]);
			ep(i < 5 ? 8'h02 : 8'h00);
		end
		ec(4'h4);
		$display("pause done");
	endtask
	task conclude;
		$display("%0d bad of %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		t_quarter; t_single; t_eight; t_stall; t_pause;
		conclude;
	end
endmodule // mtis_issue_scheduler_tb
